// ==== bsd_pkg.sv ====
package bsd_pkg;
    // ----------------------------------------------------------------
    // shift and demapping
    // ----------------------------------------------------------------
    localparam int SHIFT_W = 11;
    localparam logic [3:0] NB_RESET = 4'h8;
    localparam logic [10:0] ROOT_MAJOR0 = 11'h089;
    // ----------------------------------------------------------------
    // field values
    // ----------------------------------------------------------------
    localparam logic [1:0] BW_6MHZ = 2'h0;
    localparam logic [1:0] BW_7MHZ = 2'h1;
    localparam logic [1:0] BW_8MHZ = 2'h2;
    localparam logic [1:0] BW_WIDE = 2'h3;
    localparam logic [4:0] GAP_BANNED = 5'h1F;
    localparam logic [6:0] RATE_MAX = 7'h50;
    localparam logic [7:0] RATE_OFFSET = 8'h10;
    // sample rate step of one unit of the rate multiple, in kHz
    localparam int RATE_STEP_KHZ = 384;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h8;
    localparam logic [3:0] ADDR_RESULT = 4'hC;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_NB_LSB = 4;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_DISC_BIT = 1;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam int RES_COEF_LSB = 8;
    localparam int RES_ALERT2_BIT = 15;
    localparam int RES_WIDTH_LSB = 16;
    localparam int RES_GAP_LSB = 18;
    localparam int RES_ALERT1_BIT = 23;
    localparam int RES_DISC_BIT = 24;
    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SYM1 = 4'h2,
        ST_SYM2 = 4'h4,
        ST_SYM3 = 4'h8
    } bsd_state_t;
endpackage

// ==== bsd_demapper.sv ====
// Function
// - channel width code 00/01/10/11 decodes to 6 MHz, 7 MHz, 8 MHz and wider than 8 MHz.
// - symbol two uses its 8 most significant signaling bits, bit 0 most significant.
// - symbol two splits into alert wake bit two and a 7-bit sample-rate coefficient, MSB first.
// - coefficient N selects a sample rate of (N + 16) times 0.384 MHz.
// - coefficients 0 to 80 are valid and 81 to 127 are reserved.
// - symbol three's 8 most significant bits form the 8-bit preamble layout code.
// - the preamble layout code passes through with no validity check.
// - sequence roots 0 to 136 and 138 to 1498 are reserved for future major versions.
// - each symbol after the first delivers an 11-bit shift relative to the previous one.
// - bit 0 is shift bit 10, bit i below the count is bit (11-i) xor bit (10-i), the rest zero.
// - only the provisioned number of signaling bits is decoded, whatever the minor version.
// - with Nb bits, shift errors up to (2^(10-Nb))-1 still recover the correct bits.
// - symbol one splits into alert wake bit one, a 5-bit gap code and the 2-bit width code.
// - any reserved or undefined field value marks the whole bootstrap for discard.
// - root 137 means major version zero, the only version this field decoding covers.
module bsd_demapper
    import bsd_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic SYM_START_IN,
    input wire logic [10:0] ROOT_IN,
    input wire logic SHIFT_VALID_IN,
    input wire logic [10:0] SHIFT_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    output logic IRQ_OUT,
    output logic DONE_OUT,
    output logic DISCARD_OUT,
    output logic ALERT_WAKE_ONE_OUT,
    output logic ALERT_WAKE_TWO_OUT,
    output logic [4:0] GAP_CODE_OUT,
    output logic [1:0] WIDTH_CODE_OUT,
    output logic [3:0] WIDTH_SEL_OUT,
    output logic [6:0] RATE_COEF_OUT,
    output logic [7:0] RATE_MULT_OUT,
    output logic [7:0] PREAMBLE_OUT
);
    // ----------------------------------------------------------------
    // gray demapping
    // ----------------------------------------------------------------
    logic ctrl_en;
    logic [3:0] ctrl_nb;
    logic [10:0] demap;

    // demap[10-i] holds signaling bit i, so the top byte reads MSB first
    assign demap[10] = SHIFT_IN[10];
    for (genvar gi = 1; gi < SHIFT_W; gi++) begin : g_bit
        assign demap[10-gi] = (4'(gi) < ctrl_nb) ?
            (SHIFT_IN[11-gi] ^ SHIFT_IN[10-gi]) : 1'b0;
    end
    // errors within the tolerance never flip the upper bits because the
    // transmitter centres each symbol in its 2^(11-Nb) wide slot

    // ----------------------------------------------------------------
    // symbol sequencing
    // ----------------------------------------------------------------
    bsd_state_t state, next_state;
    logic [10:0] root, next_root;
    logic [7:0] sym1, next_sym1;
    logic [7:0] sym2, next_sym2;
    logic accept;
    logic finish;

    // shifts arrive only for symbols after the sync symbol
    assign accept = SHIFT_VALID_IN && (state != ST_IDLE) && !SYM_START_IN;
    assign finish = accept && (state == ST_SYM3);

    always_comb begin
        next_state = state;
        next_root = root;
        next_sym1 = sym1;
        next_sym2 = sym2;
        if (SYM_START_IN) begin
            // a new sync symbol restarts when enabled and idles when not, dropping a half-read set
            next_state = ctrl_en ? ST_SYM1 : ST_IDLE;
            next_root = ROOT_IN;
        end else if (accept) begin
            case (state)
                ST_SYM1: begin
                    next_sym1 = demap[10:3];
                    next_state = ST_SYM2;
                end
                ST_SYM2: begin
                    next_sym2 = demap[10:3];
                    next_state = ST_SYM3;
                end
                ST_SYM3: begin
                    next_state = ST_IDLE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= ST_IDLE;
            root <= 11'h000;
            sym1 <= 8'h00;
            sym2 <= 8'h00;
        end else begin
            state <= next_state;
            root <= next_root;
            sym1 <= next_sym1;
            sym2 <= next_sym2;
        end
    end

    // ----------------------------------------------------------------
    // field decode and discard check
    // ----------------------------------------------------------------
    logic s1_alert;
    logic [4:0] s1_gap;
    logic [1:0] s1_width;
    logic s2_alert;
    logic [6:0] s2_coef;
    logic bad_root;
    logic bad_fields;

    assign s1_alert = sym1[7];
    assign s1_gap = sym1[6:2];
    assign s1_width = sym1[1:0];
    assign s2_alert = sym2[7];
    assign s2_coef = sym2[6:0];
    // anything but the major version zero root is reserved
    assign bad_root = (root != ROOT_MAJOR0);
    // width 11 is held back by the transmitter, so seeing it is undefined
    assign bad_fields = (s1_width == BW_WIDE) || (s2_coef > RATE_MAX) ||
        (s1_gap == GAP_BANNED);

    logic next_done;
    logic next_discard;
    logic next_alert1;
    logic next_alert2;
    logic [4:0] next_gap;
    logic [1:0] next_width;
    logic [3:0] next_width_sel;
    logic [6:0] next_coef;
    logic [7:0] next_mult;
    logic [7:0] next_preamble;

    always_comb begin
        next_done = finish;
        next_discard = DISCARD_OUT;
        next_alert1 = ALERT_WAKE_ONE_OUT;
        next_alert2 = ALERT_WAKE_TWO_OUT;
        next_gap = GAP_CODE_OUT;
        next_width = WIDTH_CODE_OUT;
        next_width_sel = WIDTH_SEL_OUT;
        next_coef = RATE_COEF_OUT;
        next_mult = RATE_MULT_OUT;
        next_preamble = PREAMBLE_OUT;
        if (finish) begin
            next_discard = bad_root || bad_fields;
            next_alert1 = s1_alert;
            next_alert2 = s2_alert;
            next_gap = s1_gap;
            next_width = s1_width;
            next_width_sel = 4'h1 << s1_width;
            next_coef = s2_coef;
            // unit of this multiple is RATE_STEP_KHZ
            next_mult = {1'b0, s2_coef} + RATE_OFFSET;
            // no range check: the layout code is defined elsewhere
            next_preamble = demap[10:3];
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            DONE_OUT <= 1'b0;
            DISCARD_OUT <= 1'b0;
            ALERT_WAKE_ONE_OUT <= 1'b0;
            ALERT_WAKE_TWO_OUT <= 1'b0;
            GAP_CODE_OUT <= 5'h00;
            WIDTH_CODE_OUT <= 2'h0;
            WIDTH_SEL_OUT <= 4'h0;
            RATE_COEF_OUT <= 7'h00;
            RATE_MULT_OUT <= 8'h00;
            PREAMBLE_OUT <= 8'h00;
        end else begin
            DONE_OUT <= next_done;
            DISCARD_OUT <= next_discard;
            ALERT_WAKE_ONE_OUT <= next_alert1;
            ALERT_WAKE_TWO_OUT <= next_alert2;
            GAP_CODE_OUT <= next_gap;
            WIDTH_CODE_OUT <= next_width;
            WIDTH_SEL_OUT <= next_width_sel;
            RATE_COEF_OUT <= next_coef;
            RATE_MULT_OUT <= next_mult;
            PREAMBLE_OUT <= next_preamble;
        end
    end

    // ----------------------------------------------------------------
    // register port and interrupt
    // ----------------------------------------------------------------
    logic [1:0] status, next_status;
    logic [1:0] mask, next_mask;
    logic [1:0] events;
    logic next_ctrl_en;
    logic [3:0] next_ctrl_nb;
    logic [31:0] next_rdata;
    logic next_irq;

    assign events = {finish && (bad_root || bad_fields), finish};

    always_comb begin
        next_ctrl_en = ctrl_en;
        next_ctrl_nb = ctrl_nb;
        next_mask = mask;
        next_status = status;
        if (WR_IN && ADDR_IN == ADDR_CTRL) begin
            next_ctrl_en = WDATA_IN[CTRL_EN_BIT];
            next_ctrl_nb = WDATA_IN[CTRL_NB_LSB +: 4];
        end
        if (WR_IN && ADDR_IN == ADDR_MASK) begin
            next_mask = WDATA_IN[1:0];
        end
        if (WR_IN && ADDR_IN == ADDR_STATUS) begin
            next_status = status & ~WDATA_IN[1:0];
        end
        // a new event wins over a clear in the same cycle
        next_status = next_status | events;
        next_irq = |(next_status & next_mask);
        next_rdata = 32'h0000_0000;
        if (RD_IN) begin
            case (ADDR_IN)
                ADDR_CTRL: begin
                    next_rdata[CTRL_EN_BIT] = ctrl_en;
                    next_rdata[CTRL_NB_LSB +: 4] = ctrl_nb;
                end
                ADDR_STATUS: next_rdata[1:0] = status;
                ADDR_MASK: next_rdata[1:0] = mask;
                ADDR_RESULT: begin
                    next_rdata[7:0] = PREAMBLE_OUT;
                    next_rdata[RES_COEF_LSB +: 7] = RATE_COEF_OUT;
                    next_rdata[RES_ALERT2_BIT] = ALERT_WAKE_TWO_OUT;
                    next_rdata[RES_WIDTH_LSB +: 2] = WIDTH_CODE_OUT;
                    next_rdata[RES_GAP_LSB +: 5] = GAP_CODE_OUT;
                    next_rdata[RES_ALERT1_BIT] = ALERT_WAKE_ONE_OUT;
                    next_rdata[RES_DISC_BIT] = DISCARD_OUT;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_en <= CTRL_EN_RESET;
            ctrl_nb <= NB_RESET;
            mask <= MASK_RESET;
            status <= STATUS_RESET;
            RDATA_OUT <= 32'h0000_0000;
            IRQ_OUT <= 1'b0;
        end else begin
            ctrl_en <= next_ctrl_en;
            ctrl_nb <= next_ctrl_nb;
            mask <= next_mask;
            status <= next_status;
            RDATA_OUT <= next_rdata;
            IRQ_OUT <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_last_shift;
        SHIFT_VALID_IN && !SYM_START_IN && state == ST_SYM3;
    endsequence
    sequence s_single_pulse;
        DONE_OUT ##1 !DONE_OUT;
    endsequence

    property p_done_pulse;
        s_last_shift |=> s_single_pulse;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("valid strobe wrong");

    property p_width_sel;
        DONE_OUT |-> WIDTH_SEL_OUT == (4'h1 << WIDTH_CODE_OUT);
    endproperty
    a_width_sel: assert property (p_width_sel) else $error("width decode wrong");

    property p_rate;
        DONE_OUT |-> RATE_MULT_OUT == {1'b0, RATE_COEF_OUT} + RATE_OFFSET;
    endproperty
    a_rate: assert property (p_rate) else $error("rate multiple wrong");

    property p_coef_reserved;
        DONE_OUT && RATE_COEF_OUT > RATE_MAX |-> DISCARD_OUT;
    endproperty
    a_coef_reserved: assert property (p_coef_reserved) else $error("coef not flagged");

    property p_discard;
        DONE_OUT && !DISCARD_OUT |-> WIDTH_CODE_OUT != BW_WIDE &&
            GAP_CODE_OUT != GAP_BANNED && root == ROOT_MAJOR0;
    endproperty
    a_discard: assert property (p_discard) else $error("discard missed");

    property p_root;
        SYM_START_IN && ROOT_IN != ROOT_MAJOR0 ##1 (!SYM_START_IN)[*4] ##0 DONE_OUT
            |-> DISCARD_OUT;
    endproperty
    a_root: assert property (p_root) else $error("reserved root kept");

    property p_preamble;
        s_last_shift |=> PREAMBLE_OUT == $past(demap[10:3]);
    endproperty
    a_preamble: assert property (p_preamble) else $error("layout code wrong");

    property p_demap_top;
        ctrl_nb > 4'h1 |-> demap[10] == SHIFT_IN[10] &&
            demap[9] == (SHIFT_IN[10] ^ SHIFT_IN[9]);
    endproperty
    a_demap_top: assert property (p_demap_top) else $error("gray demap wrong");

    property p_unprovisioned;
        ctrl_nb <= 4'h8 |-> demap[2:0] == 3'h0;
    endproperty
    a_unprovisioned: assert property (p_unprovisioned) else $error("extra bits decoded");

    property p_sym2;
        state == ST_SYM2 && SHIFT_VALID_IN && !SYM_START_IN |=> sym2 == $past(demap[10:3]);
    endproperty
    a_sym2: assert property (p_sym2) else $error("symbol two bits wrong");

    property p_irq;
        |(status & mask) |-> IRQ_OUT;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule

// ==== bsd_shift_model.sv ====
// ----------------------------------------------------------------
// cyclic shift estimator stand-in: start pulse, root, three shifts
// ----------------------------------------------------------------
module bsd_shift_model (
    input wire logic clk_in,
    input wire logic rst_in,
    output logic sym_start_out,
    output logic [10:0] root_out,
    output logic shift_valid_out,
    output logic [10:0] shift_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sym_start_out = 1'b0;
        root_out = 11'h000;
        shift_valid_out = 1'b0;
        shift_out = 11'h000;
    end

    // gray map the eight bits; the low bits sit mid-slot so an error of +-3 stays inside it
    function automatic logic [10:0] map_bits(input logic [7:0] b, input int err);
        logic [10:0] m;
        int i;
        m = 11'h004;
        m[10] = b[7];
        for (i = 1; i < 8; i++) begin
            m[10-i] = m[11-i] ^ b[7-i];
        end
        return m + 11'(err);
    endfunction

    // the width, coefficient and root values are sent as the caller commands, reserved ones
    // included, so that discard handling can be exercised
    task automatic send(input logic [10:0] rt, input logic [7:0] b1, input logic [7:0] b2,
            input logic [7:0] b3, input int err);
        while (rst_in) @(posedge clk_in);
        @(posedge clk_in);
        sym_start_out <= 1'b1;
        root_out <= rt;
        @(posedge clk_in);
        sym_start_out <= 1'b0;
        root_out <= ~rt;
        shift_valid_out <= 1'b1;
        shift_out <= map_bits(b1, err);
        @(posedge clk_in);
        shift_out <= map_bits(b2, -err);
        @(posedge clk_in);
        shift_out <= map_bits(b3, err);
        @(posedge clk_in);
        shift_valid_out <= 1'b0;
        // a released line shows the inverse, never a stale copy
        shift_out <= ~map_bits(b3, err);
    endtask

    // a cut set: sync symbol and one shift, then silence
    task automatic part(input logic [10:0] rt, input logic [7:0] b1);
        while (rst_in) @(posedge clk_in);
        @(posedge clk_in);
        sym_start_out <= 1'b1;
        root_out <= rt;
        @(posedge clk_in);
        sym_start_out <= 1'b0;
        root_out <= ~rt;
        shift_valid_out <= 1'b1;
        shift_out <= map_bits(b1, 0);
        @(posedge clk_in);
        shift_valid_out <= 1'b0;
        shift_out <= ~map_bits(b1, 0);
    endtask
endmodule

// ==== bsd_demapper_tb.sv ====
module bsd_demapper_tb
    import bsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start, sv, wr = 1'b0, rd = 1'b0, irq, done, disc, a1, a2;
    logic [10:0] root, shift;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [4:0] gap;
    logic [1:0] wc;
    logic [3:0] wsel;
    logic [6:0] coef;
    logic [7:0] mult, pre;
    int mismatches = 0, tests_run = 0, cycles = 0, k;
    logic [10:0] roots [4] = '{11'h088, 11'h08A, 11'h5DA, 11'h000};
    always #2.5 clk = ~clk;

    bsd_shift_model model_u (.clk_in(clk), .rst_in(rst), .sym_start_out(start),
        .root_out(root), .shift_valid_out(sv), .shift_out(shift));
    bsd_demapper dut_u (.CLK_IN(clk), .RST_IN(rst), .SYM_START_IN(start), .ROOT_IN(root),
        .SHIFT_VALID_IN(sv), .SHIFT_IN(shift), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .DONE_OUT(done), .DISCARD_OUT(disc),
        .ALERT_WAKE_ONE_OUT(a1), .ALERT_WAKE_TWO_OUT(a2), .GAP_CODE_OUT(gap),
        .WIDTH_CODE_OUT(wc), .WIDTH_SEL_OUT(wsel), .RATE_COEF_OUT(coef),
        .RATE_MULT_OUT(mult), .PREAMBLE_OUT(pre));

    // ----------------------------------------------------------------
    // checking and bus helpers
    // ----------------------------------------------------------------
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", rdata, exp);
    endtask

    // one bootstrap; nb trims the bits that are not provisioned
    task frame(input logic [10:0] rt, input logic [7:0] b1, input logic [7:0] b2,
            input logic [7:0] b3, input int err, input int nb);
        logic [7:0] m, e1, e2, e3;
        logic dx;
        m = 8'hFF << (8 - nb);
        e1 = b1 & m;
        e2 = b2 & m;
        e3 = b3 & m;
        dx = rt !== ROOT_MAJOR0 || e1[1:0] == BW_WIDE || e2[6:0] > RATE_MAX
            || e1[6:2] == GAP_BANNED;
        model_u.send(rt, b1, b2, b3, err);
        #1 chk("done", done, 1'b1);
        chk("discard", disc, dx);
        chk("alert1", a1, e1[7]);
        chk("gap", gap, e1[6:2]);
        chk("width", wc, e1[1:0]);
        chk("width_sel", wsel, 4'h1 << e1[1:0]);
        chk("alert2", a2, e2[7]);
        chk("coef", coef, e2[6:0]);
        chk("mult", mult, {1'b0, e2[6:0]} + RATE_OFFSET);
        chk("preamble", pre, e3);
        @(posedge clk);
        #1 chk("done_pulse", done, 1'b0);
        chk("held", pre, e3);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task test_reset;
        rd_reg(ADDR_CTRL, {24'h0, NB_RESET, 3'h0, CTRL_EN_RESET});
        rd_reg(ADDR_STATUS, 32'h0);
        rd_reg(ADDR_MASK, 32'h0);
        rd_reg(4'h2, 32'h0);
        @(posedge clk);
        #1 chk("rdata_idle", rdata, 32'h0);
        chk("irq_reset", irq, 1'b0);
    endtask

    // a new sync symbol drops a half-read set; a mid-run reset clears the results
    task test_restart;
        model_u.part(ROOT_MAJOR0, 8'h7C);
        frame(ROOT_MAJOR0, 8'h24, 8'h30, 8'h99, 1, 8);
        model_u.part(ROOT_MAJOR0, 8'h24);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("reset_done", done, 1'b0);
        chk("reset_preamble", pre, 8'h00);
        chk("reset_gap", gap, 5'h00);
        chk("reset_irq", irq, 1'b0);
        rd_reg(ADDR_STATUS, 32'h0);
        frame(ROOT_MAJOR0, 8'h24, 8'h30, 8'h99, -2, 8);
    endtask

    task test_widths;
        for (k = 0; k < 4; k++) begin
            frame(ROOT_MAJOR0, {1'b1, 5'(k * 7), 2'(k)}, {1'b0, 7'(k * 20)}, 8'(k * 85),
                (k % 2 == 1) ? 3 : -3, 8);
        end
    endtask

    task test_rates;
        logic [6:0] c [4] = '{7'h00, 7'h50, 7'h51, 7'h7F};
        for (k = 0; k < 4; k++) begin
            frame(ROOT_MAJOR0, 8'h5A, {k[0], c[k]}, {c[k], k[1]}, (k < 2) ? 3 : -3, 8);
        end
    endtask

    task test_roots;
        for (k = 0; k < 4; k++) begin
            frame(roots[k], 8'h00, 8'h10, 8'hC3, 0, 8);
        end
        frame(ROOT_MAJOR0, 8'h7C, 8'h10, 8'hC3, 2, 8);
    endtask

    task test_irq;
        wr_reg(ADDR_STATUS, 32'h3);
        wr_reg(ADDR_MASK, 32'h1);
        frame(ROOT_MAJOR0, 8'hA6, 8'hD0, 8'h3C, 1, 8);
        #1 chk("irq_done", irq, 1'b1);
        rd_reg(ADDR_STATUS, 32'h1);
        rd_reg(ADDR_RESULT, 32'h00A6D03C);
        wr_reg(ADDR_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk("irq_clear", irq, 1'b0);
        wr_reg(ADDR_MASK, 32'h2);
        frame(11'h088, 8'h00, 8'h00, 8'h00, 0, 8);
        #1 chk("irq_discard", irq, 1'b1);
        rd_reg(ADDR_STATUS, 32'h3);
        wr_reg(ADDR_STATUS, 32'h3);
        repeat (2) @(posedge clk);
        #1 chk("irq_off", irq, 1'b0);
    endtask

    task test_nb;
        wr_reg(ADDR_CTRL, 32'h41);
        frame(ROOT_MAJOR0, 8'hFF, 8'h7F, 8'hA5, -1, 4);
        frame(ROOT_MAJOR0, 8'h28, 8'h47, 8'h1E, 3, 4);
        wr_reg(ADDR_CTRL, 32'h80);
        model_u.send(ROOT_MAJOR0, 8'h00, 8'h00, 8'h00, 0);
        #1 chk("disabled", done, 1'b0);
        wr_reg(ADDR_CTRL, 32'h81);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_widths();
        test_rates();
        test_roots();
        test_irq();
        test_restart();
        test_nb();
        close_out();
    end
endmodule
